// ==== sse_top.sv ====
// supply sequencing state engine with wishbone register slave
`timescale 1ns/1ns
`include "sse_cfg.svh"
module sse_top
  import sse_pkg::*;
#(
  parameter int BOOT_CYC = `SSE_CYC(`SSE_BOOT_NS)
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  input  wire logic [`SSE_NIN-1:0]  sfd_i,
  input  wire logic [`SSE_NLOG-1:0] logic_in_i,
  input  wire logic [`SSE_NWARN-1:0] warn_i,
  input  wire logic                 cfg_done_i,
  output logic [`SSE_NIN-1:0]       pdo_o,
  output logic                      irq_o
);
  localparam int FETCH_CYC = `SSE_CYC(`SSE_FETCH_NS);
  localparam int TICK_CYC  = `SSE_CYC(`SSE_TICK_NS);
  localparam int FETCH_MAX = FETCH_CYC + 1;
  localparam int CNTW      = 16;

  // timer field: two range bits select 1/10/100/1000 ticks of 10 us
  function automatic logic [`SSE_CW-1:0] dly_cyc(input logic [7:0] f);
    logic [`SSE_CW-1:0] sc;
    sc = '0;
    case (f[7:6])
      2'h0:    sc = `SSE_CW'(1);
      2'h1:    sc = `SSE_CW'(10);
      2'h2:    sc = `SSE_CW'(100);
      default: sc = `SSE_CW'(1000);
    endcase
    dly_cyc = `SSE_CW'(f[5:0] * sc * TICK_CYC);
  endfunction

  //===================================================================
  // input synchronisers
  logic [`SSE_NIN+`SSE_NLOG+`SSE_NWARN:0] sy1_q;
  logic [`SSE_NIN+`SSE_NLOG+`SSE_NWARN:0] sy2_q;
  wire  [`SSE_NIN-1:0]  supply_fault_detector;
  wire  [`SSE_NLOG-1:0] lgc;
  wire                  warn;
  wire                  cfg_done;
  // pins are asynchronous; two flops before any reader
  always_ff @(posedge clk_i)
  begin
    sy1_q <= {cfg_done_i, warn_i, logic_in_i, sfd_i};
    sy2_q <= sy1_q;
  end
  assign supply_fault_detector      = sy2_q[`SSE_NIN-1:0];
  assign lgc      = sy2_q[`SSE_NIN+`SSE_NLOG-1:`SSE_NIN];
  assign warn     = |sy2_q[`SSE_NIN+`SSE_NLOG+`SSE_NWARN-1:
                           `SSE_NIN+`SSE_NLOG];
  assign cfg_done = sy2_q[`SSE_NIN+`SSE_NLOG+`SSE_NWARN];

  //===================================================================
  // state definition store (index 63 reserved)
  // state cell storage
  sse_def_t       mem [`SSE_NST];
  sse_state_e     st_q;
  logic [5:0]     cur_q;
  logic [5:0]     nxt_q;
  sse_def_t       def_q;
  logic [`SSE_NIN-1:0] pdo_q;
  logic [`SSE_CW-1:0]  seq_cnt_q;
  logic [`SSE_CW-1:0]  tmo_cnt_q;
  logic                seq_prev_q;
  logic [`SSE_CW-1:0]  wait_q;
  logic                jump_q;
  logic [5:0]     daddr_q;
  logic [31:0]    dlo_q;
  logic [3:0]     istat_q;
  logic [3:0]     imask_q;
  logic           irq_q;
  logic           ack_q;
  logic [31:0]    dat_q;
  logic           warn_q;

  //===================================================================
  // wishbone decode
  wire req      = cyc_i & stb_i;
  wire wr_take  = req & we_i & ack_q;
  wire sel_ctrl = adr_i == `SSE_R_CTRL;
  wire sel_ist  = adr_i == `SSE_R_ISTAT;
  wire sel_imk  = adr_i == `SSE_R_IMASK;
  wire sel_dad  = adr_i == `SSE_R_DADDR;
  wire sel_dlo  = adr_i == `SSE_R_DLO;
  wire sel_dhi  = adr_i == `SSE_R_DHI;
  wire jump_wr  = wr_take & sel_ctrl & sel_i[0] & dat_i[`SSE_B_JUMP];
  // reserved cell never written, though a target field may still name it
  wire mem_wr   = wr_take & sel_dhi & (daddr_q != `SSE_LAST_ST);
  wire [31:0] rd_data =
    (adr_i == `SSE_R_STAT)  ? {24'h0, st_q == SSE_FETCH,
                               st_q == SSE_RUN, cur_q} :
    sel_ist ? {28'h0, istat_q} :
    sel_imk ? {28'h0, imask_q} :
    sel_dad ? {26'h0, daddr_q} :
    sel_dlo ? mem[daddr_q][31:0] :
    sel_dhi ? mem[daddr_q][63:32] : 32'h0;

  // one wait cycle: ack follows the request, dropped after one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      dat_q <= rd_data;
    end
  end

  // software-written configuration; definition commits on high word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      daddr_q <= 6'h0;
      dlo_q   <= 32'h0;
      imask_q <= 4'h0;
    end
    else if (wr_take)
    begin
      if (sel_dad)
        daddr_q <= dat_i[5:0];
      if (sel_dlo)
        dlo_q <= dat_i;
      if (sel_imk)
        imask_q <= dat_i[3:0];
    end
  end

  // any cell may hold any target
  always_ff @(posedge clk_i)
  begin
    if (mem_wr)
      mem[daddr_q] <= {dat_i, dlo_q};
  end

  //===================================================================
  // exit detectors
  wire [15:0] eng_in = {warn, lgc, supply_fault_detector};
  // all ten inputs plus logic inputs are selectable
  wire seq_in  = eng_in[def_q[`SSE_F_SEQ_SEL]];
  wire seq_ok  = def_q[`SSE_F_SEQ_EN] &
                 (seq_in == def_q[`SSE_F_SEQ_LVL]);
  wire [`SSE_CW-1:0] seq_dly = dly_cyc(def_q[`SSE_F_SEQ_DLY]);
  wire [`SSE_CW-1:0] tmo_dly = dly_cyc(def_q[`SSE_F_TMO_DLY]);
  // level reached and held for the delay
  wire seq_hit = seq_ok & (seq_cnt_q >= seq_dly);
  // wide OR of deviations, no delay
  wire mon_hit = |(def_q[`SSE_F_MON_MSK] & ~supply_fault_detector) |
                 (def_q[`SSE_F_MON_WRN] & warn);
  // interval expired before the sequence exit
  wire tmo_hit = ((tmo_dly != '0) & (tmo_cnt_q >= tmo_dly)) |
                 (def_q[`SSE_F_TMO_WRN] & warn);
  wire run     = st_q == SSE_RUN;
  // jump acts on sequence and timeout routes
  wire seq_go  = seq_hit | jump_q;
  wire tmo_go  = tmo_hit | jump_q;
  // monitor first, then sequence, then timeout
  // three exits each with its own target
  wire [5:0] tgt = mon_hit ? def_q[`SSE_F_MON_NXT] :
                   seq_go  ? def_q[`SSE_F_SEQ_NXT] :
                             def_q[`SSE_F_TMO_NXT];
  wire exit_now = run & (mon_hit | seq_go | tmo_go);
  wire wait_end = wait_q == '0;

  //===================================================================
  // engine state machine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= SSE_WAIT_CFG;
      cur_q  <= `SSE_FIRST_ST;
      nxt_q  <= `SSE_FIRST_ST;
      def_q  <= '0;
      pdo_q  <= '0;
      wait_q <= '0;
    end
    else
    begin
      wait_q <= wait_end ? '0 : wait_q - 1'b1;
      case (st_q)
        SSE_WAIT_CFG:
          if (cfg_done)
          begin
            st_q   <= SSE_BOOT;
            wait_q <= `SSE_CW'(BOOT_CYC - 1);
          end
        SSE_BOOT:
          if (wait_end)
          begin
            st_q   <= SSE_FETCH;
            wait_q <= `SSE_CW'(FETCH_CYC - 1);
          end
        SSE_FETCH:
          if (wait_end)
          begin
            st_q  <= SSE_RUN;
            cur_q <= nxt_q;
            def_q <= mem[nxt_q];
            // outputs change only at the load
            pdo_q <= mem[nxt_q][`SSE_F_PDO];
          end
        SSE_RUN:
          if (exit_now)
          begin
            st_q   <= SSE_FETCH;
            nxt_q  <= tgt;
            wait_q <= `SSE_CW'(FETCH_CYC - 1);
          end
        default:
          st_q <= SSE_WAIT_CFG;
      endcase
    end
  end

  //===================================================================
  // sequence and timeout timers
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run)
    begin
      // both timers reload on every state change
      seq_cnt_q  <= '0;
      tmo_cnt_q  <= '0;
      seq_prev_q <= 1'b0;
    end
    else
    begin
      seq_prev_q <= seq_in;
      if (seq_in != seq_prev_q)
        seq_cnt_q <= '0;
      else if (seq_cnt_q != '1)
        seq_cnt_q <= seq_cnt_q + 1'b1;
      if (tmo_cnt_q != '1)
        tmo_cnt_q <= tmo_cnt_q + 1'b1;
    end
  end

  // jump stays pending until the running engine next exits a state by any route
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      jump_q <= 1'b0;
    else if (jump_wr)
      jump_q <= 1'b1;
    else if (exit_now)
      jump_q <= 1'b0;
  end

  //===================================================================
  // interrupt status: seq, monitor, timeout exits and warning rise
  wire [3:0] ev = {warn & ~warn_q,
                   exit_now & ~mon_hit & ~seq_go,
                   exit_now & mon_hit,
                   exit_now & ~mon_hit & seq_go};
  wire [3:0] clr = (wr_take & sel_ist) ? dat_i[3:0] : 4'h0;
  wire [3:0] istat_d = ev | (istat_q & ~clr);
  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      istat_q <= 4'h0;
      irq_q   <= 1'b0;
      warn_q  <= 1'b0;
    end
    else
    begin
      istat_q <= istat_d;
      irq_q   <= |(istat_d & imask_q);
      warn_q  <= warn;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign pdo_o = pdo_q;
  assign irq_o = irq_q;

  //===================================================================
  // assertions
  a_pdo_hold_run: assert property (@(posedge clk_i) disable iff (rst_i)
    run && $past(run) |-> $stable(pdo_q))
    else $error("driver outputs moved inside a state");
  a_mon_exit_first: assert property (@(posedge clk_i)
    disable iff (rst_i) run && mon_hit
    |=> st_q == SSE_FETCH && nxt_q == $past(def_q[`SSE_F_MON_NXT]))
    else $error("monitor exit not taken at once");
  a_seq_exit_tgt: assert property (@(posedge clk_i)
    disable iff (rst_i) run && seq_hit && !mon_hit
    |=> nxt_q == $past(def_q[`SSE_F_SEQ_NXT]))
    else $error("sequence exit target wrong");
  a_tmo_exit_tgt: assert property (@(posedge clk_i)
    disable iff (rst_i) run && tmo_hit && !mon_hit && !seq_go
    |=> nxt_q == $past(def_q[`SSE_F_TMO_NXT]))
    else $error("timeout exit target wrong");
  a_fetch_time_max: assert property (@(posedge clk_i)
    disable iff (rst_i) $rose(st_q == SSE_FETCH)
    |-> ##[1:FETCH_MAX] st_q == SSE_RUN)
    else $error("state fetch took too long");
  a_timer_reload: assert property (@(posedge clk_i)
    disable iff (rst_i) $rose(run) |-> seq_cnt_q == '0 &&
    tmo_cnt_q == '0)
    else $error("timers not reloaded on state entry");
  a_seq_restart: assert property (@(posedge clk_i)
    disable iff (rst_i) run && $past(run) && seq_in != seq_prev_q
    && !exit_now |=> seq_cnt_q == '0)
    else $error("sequence delay not restarted");
  a_jump_advance: assert property (@(posedge clk_i)
    disable iff (rst_i) run && jump_q && !mon_hit
    |=> st_q == SSE_FETCH && nxt_q == $past(def_q[`SSE_F_SEQ_NXT]))
    else $error("jump did not advance");
  c_mon_exit: cover property (@(posedge clk_i) run && mon_hit);
  c_tmo_exit: cover property (@(posedge clk_i)
    run && tmo_hit && !mon_hit && !seq_go);
  c_jump_exit: cover property (@(posedge clk_i) run && jump_q);
endmodule

// ==== sse_cfg.svh ====
// constants for the supply sequencing state engine
//=====================================================================
// Summary of operation
// - sixty-three programmable state cells, independent definitions
// - every state observes all ten supervised inputs
// - any state may target any other state
// - three exits: sequence, monitor, timeout
// - both timers reload on every state change
// - driver outputs fixed while state holds
// - state change completes within twenty microseconds
// - inputs are supply fault detector outputs
// - warning sources ORed, offered to every exit
// - jump command forces sequence-route advance
// - sequence exit on input level, optional delay
// - input change during delay restarts timer
// - monitor exit is wide OR of deviations
// - monitor exit has no programmable delay
// - timeout exit traps stalled sequence step
// - dual-function logic inputs selectable by engine
// - first state loads half millisecond after configuration
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH
//=====================================================================
// timing
`define SSE_CLK_MHZ     50
`define SSE_FETCH_NS    10000
`define SSE_BOOT_NS     500000
`define SSE_TICK_NS     10000
`define SSE_CYC(ns)     (((ns) * `SSE_CLK_MHZ) / 1000)
//=====================================================================
// sizes
`define SSE_NIN         10
`define SSE_NLOG        5
`define SSE_NWARN       6
`define SSE_NST         64
`define SSE_LAST_ST     6'h3f
`define SSE_FIRST_ST    6'h00
`define SSE_CW          25
//=====================================================================
// state definition word fields
`define SSE_F_PDO       9:0
`define SSE_F_SEQ_NXT   15:10
`define SSE_F_MON_NXT   21:16
`define SSE_F_TMO_NXT   27:22
`define SSE_F_SEQ_SEL   31:28
`define SSE_F_SEQ_LVL   32
`define SSE_F_MON_MSK   42:33
`define SSE_F_MON_WRN   43
`define SSE_F_TMO_WRN   45
`define SSE_F_SEQ_DLY   53:46
`define SSE_F_TMO_DLY   61:54
`define SSE_F_SEQ_EN    62
//=====================================================================
// register byte offsets
`define SSE_R_CTRL      8'h00
`define SSE_R_STAT      8'h04
`define SSE_R_ISTAT     8'h08
`define SSE_R_IMASK     8'h0c
`define SSE_R_DADDR     8'h10
`define SSE_R_DLO       8'h14
`define SSE_R_DHI       8'h18
`define SSE_B_JUMP      0
`define SSE_NIRQ        4
`endif

// ==== sse_pkg.sv ====
// types for the supply sequencing state engine
package sse_pkg;
  typedef enum logic [1:0] {
    SSE_WAIT_CFG,
    SSE_BOOT,
    SSE_FETCH,
    SSE_RUN
  } sse_state_e;
  typedef logic [63:0] sse_def_t;
endpackage

// ==== sse_rails.sv ====
// supply rail model that answers the driver outputs of the engine
`timescale 1ns/1ns
module sse_rails #(
  parameter int RISE_CYC = 50
)
(
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       main_ok_i,
  output logic      [9:0] sfd_o
);
  int cnt_q;
  //===================================================================
  // rail ramp
  // ramp counter restarts whenever the enable drops, as a real rail would
  always_ff @(posedge clk_i)
  begin
    if (!en_i)
      cnt_q <= 0;
    else if (cnt_q < RISE_CYC)
      cnt_q <= cnt_q + 1;
  end
  // comparator okay flags
  // rail 0 is the main input, rail 1 the switched one, rest stay low
  assign sfd_o = {8'h00, (cnt_q == RISE_CYC), main_ok_i};
endmodule

// ==== tb_sse_top.sv ====
// self-checking testbench for the supply sequencing state engine
`timescale 1ns/1ns
`include "sse_cfg.svh"
module tb_sse_top
  import sse_pkg::*;
;
  localparam int BOOT = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        cfg_done = 1'b0;
  logic        main_ok = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] r;
  logic [5:0]  warn = 6'h00;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_o;
  logic [9:0]  pdo_o;
  logic [9:0]  supply_fault_detector;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc_n;
  always #10 clk_i = ~clk_i;
  sse_top #(.BOOT_CYC(BOOT)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .sfd_i(supply_fault_detector),
    .logic_in_i(5'h00), .warn_i(warn), .cfg_done_i(cfg_done),
    .pdo_o(pdo_o), .irq_o(irq_o));
  sse_rails rails (.clk_i(clk_i), .en_i(pdo_o[0]), .main_ok_i(main_ok),
    .sfd_o(supply_fault_detector));
  //===================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // one classic cycle, held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    if (n >= 50)
      err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_pdo(input logic [9:0] e);
    cyc_n = 0;
    while (pdo_o !== e && cyc_n < 3000)
    begin
      @(posedge clk_i);
      cyc_n++;
    end
    chk("pdo_o", {22'h0, e}, {22'h0, pdo_o});
  endtask
  function automatic sse_def_t mk(logic [9:0] p, logic [5:0] sn, mn, tn,
    logic [3:0] sl, logic [9:0] msk, logic [7:0] td, logic se);
    sse_def_t d;
    d = '0;
    d[`SSE_F_PDO] = p;
    d[`SSE_F_SEQ_NXT] = sn;
    d[`SSE_F_MON_NXT] = mn;
    d[`SSE_F_TMO_NXT] = tn;
    d[`SSE_F_SEQ_SEL] = sl;
    d[`SSE_F_SEQ_LVL] = 1'b1;
    d[`SSE_F_MON_MSK] = msk;
    d[`SSE_F_TMO_DLY] = td;
    d[`SSE_F_SEQ_EN] = se;
    return d;
  endfunction
  task automatic def_wr(input logic [5:0] c, input sse_def_t d);
    wb(1'b1, `SSE_R_DADDR, {26'h0, c});
    wb(1'b1, `SSE_R_DLO, d[31:0]);
    wb(1'b1, `SSE_R_DHI, d[63:32]);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //===================================================================
  // watchdog: the whole run needs well under ten thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    give_verdict;
  end
  //===================================================================
  // tests
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, r);
    def_wr(6'h00, mk(10'h001, 6'h01, 0, 0, 4'h1, 0, 0, 1));
    def_wr(6'h01, mk(10'h003, 0, 6'h02, 0, 0, 10'h001, 0, 0));
    def_wr(6'h02, mk(10'h004, 6'h05, 0, 0, 4'h2, 0, 0, 1));
    def_wr(6'h05, mk(10'h3f0, 0, 0, 6'h06, 0, 0, 8'h01, 0));
    def_wr(6'h06, mk(10'h020, 0, 0, 0, 0, 0, 0, 0));
    wb(1'b0, `SSE_R_DHI, 32'h0);
    // high word of cell 6 carries only the required-level bit
    chk("cell readback", 32'h1, r);
    wb(1'b1, `SSE_R_IMASK, 32'h2);
    cfg_done <= 1'b1;
    wait_pdo(10'h001);
    chk("boot delay", 1, cyc_n >= BOOT + 500 && cyc_n <= BOOT + 510);
    $display("test boot done");
    wait_pdo(10'h003);
    wb(1'b0, `SSE_R_ISTAT, 32'h0);
    chk("seq exit flag", 32'h1, {28'h0, r[3:0]});
    wb(1'b1, `SSE_R_ISTAT, 32'h1);
    $display("test sequence done");
    main_ok <= 1'b0;
    wait_pdo(10'h004);
    chk("monitor latency", 1, cyc_n <= 1000);
    chk("irq raised", 1, irq_o);
    wb(1'b1, `SSE_R_ISTAT, 32'h2);
    @(posedge clk_i);
    chk("irq cleared", 0, irq_o);
    $display("test monitor done");
    wb(1'b1, `SSE_R_CTRL, 32'h1);
    wait_pdo(10'h3f0);
    $display("test jump done");
    wait_pdo(10'h020);
    chk("timeout span", 1, cyc_n >= 990 && cyc_n <= 1100);
    wb(1'b0, `SSE_R_ISTAT, 32'h0);
    chk("jump and timeout", 32'h5, {28'h0, r[3:0]});
    wb(1'b0, `SSE_R_STAT, 32'h0);
    chk("state number", 32'h46, {25'h0, r[6:0]});
    $display("test timeout done");
    warn <= 6'h20;
    repeat (5) @(posedge clk_i);
    wb(1'b0, `SSE_R_ISTAT, 32'h0);
    chk("warning flag", 1, r[3]);
    chk("pdo held", 32'h020, {22'h0, pdo_o});
    $display("test warning done");
    give_verdict;
  end
endmodule
